// ### rtl/pcm_pkg.sv
`default_nettype none
package pcm_pkg;
  // ---------------------------------------------------------------
  // register word indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_GCONF = 8'h00;
  localparam logic [7:0] IDX_RCONF = 8'h01;
  localparam logic [7:0] IDX_STATUS = 8'h0F;
  localparam logic [7:0] IDX_ACTUAL = 8'h21;
  localparam logic [7:0] IDX_COMPARE = 8'h32;
  localparam logic [7:0] IDX_VLEFT = 8'h33;
  localparam logic [7:0] IDX_VRIGHT = 8'h34;
  localparam logic [7:0] IDX_RANGE = 8'h36;
  localparam logic [7:0] IDX_TARGET = 8'h37;
  localparam logic [7:0] IDX_FRAC = 8'h7C;

  // ---------------------------------------------------------------
  // general_configuration bits
  // ---------------------------------------------------------------
  localparam int unsigned GC_POSMODE = 0;
  localparam int unsigned GC_PULL = 4;
  localparam int unsigned GC_WAND = 5;
  localparam int unsigned GC_REVRD = 6;
  localparam int unsigned GC_INVPOL = 16;

  // ---------------------------------------------------------------
  // reference_configuration bits
  // ---------------------------------------------------------------
  localparam int unsigned RC_ARR_SRC = 0;
  localparam int unsigned RC_CMP_SRC = 2;
  localparam int unsigned RC_CMP_SEL = 3;
  localparam int unsigned RC_CLR_AT = 5;
  localparam int unsigned RC_CIRC = 6;
  localparam int unsigned RC_VL_EN = 7;
  localparam int unsigned RC_VR_EN = 8;

  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    PCM_ARR_TARGET = 2'b00,
    PCM_ARR_VEL = 2'b01,
    PCM_ARR_UNDEF = 2'b10,
    PCM_ARR_CMP = 2'b11
  } pcm_arr_src_t;

  typedef enum logic [1:0] {
    PCM_CMP_POS_VAL = 2'b00,
    PCM_CMP_POS_HOME = 2'b01,
    PCM_CMP_POS_LATCH = 2'b10,
    PCM_CMP_REV_VAL = 2'b11
  } pcm_cmp_sel_t;
endpackage
`default_nettype wire

// ### rtl/pcm_circ_pos.sv
`timescale 1ns/100ps
`default_nettype none
module pcm_circ_pos #(
  parameter int unsigned POS_W = 32,
  parameter int unsigned FRAC_W = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic step_i,
  input wire logic step_up_i,
  input wire logic load_i,
  input wire logic [POS_W-1:0] load_val_i,
  input wire logic clear_i,
  input wire logic circ_on_i,
  input wire logic [POS_W-1:0] range_i,
  input wire logic [FRAC_W-1:0] frac_i,
  output logic [POS_W-1:0] actual_o,
  output logic [POS_W-1:0] revs_o
);
  logic [POS_W-1:0] pos_reg;
  logic [POS_W-1:0] rev_reg;
  logic [FRAC_W-2:0] acc_reg;
  logic hold_reg;
  logic [1:0] left_reg;
  logic [1:0] extra;
  logic [POS_W-1:0] top_pos;
  logic [POS_W-1:0] bot_pos;
  logic at_top;
  logic at_bot;
  logic wrap;
  logic wrap_go;
  logic [FRAC_W:0] acc_sum;

  assign top_pos = range_i - POS_W'(1);
  assign bot_pos = POS_W'(~range_i + POS_W'(1));
  assign at_top = circ_on_i && step_up_i && (pos_reg == top_pos);
  assign at_bot = circ_on_i && !step_up_i && (pos_reg == bot_pos);
  // a load or clear wins over the step, so it must not count as a wrap
  assign wrap = step_i && !load_i && !clear_i && (at_top || at_bot);
  // increment is one integer bit and 31 fraction bits; the integer part of the sum
  // is the number of extra steps held at the wrap point (up to two)
  assign acc_sum = {2'b00, acc_reg} + {1'b0, frac_i};
  assign extra = acc_sum[FRAC_W:FRAC_W-1];
  assign wrap_go = wrap && (hold_reg ? (left_reg == 2'h0) : (extra == 2'h0));
  assign actual_o = pos_reg;
  assign revs_o = rev_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_reg <= '0;
    end else if (load_i) begin
      pos_reg <= load_val_i;
    end else if (clear_i) begin
      pos_reg <= '0;
    end else if (step_i) begin
      if (wrap) begin
        if (wrap_go) begin
          pos_reg <= at_top ? bot_pos : top_pos;
        end
      end else begin
        pos_reg <= step_up_i ? pos_reg + POS_W'(1) : pos_reg - POS_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !circ_on_i) begin
      acc_reg <= '0;
      hold_reg <= 1'b0;
      left_reg <= 2'h0;
    end else if (wrap) begin
      if (!hold_reg) begin
        acc_reg <= acc_sum[FRAC_W-2:0];
        hold_reg <= (extra != 2'h0);
        left_reg <= extra - 2'h1;
      end else if (left_reg != 2'h0) begin
        left_reg <= left_reg - 2'h1;
      end else begin
        hold_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !circ_on_i) begin
      rev_reg <= '0;
    end else if (wrap_go) begin
      rev_reg <= at_top ? rev_reg + POS_W'(1) : rev_reg - POS_W'(1);
    end
  end
endmodule // pcm_circ_pos
`default_nettype wire

// ### rtl/pcm_position_supervisor.sv
// Behaviour
// - shared-line modes act only once the pull drive enable is set
// - wired-or: inactive level weak, active level strong
// - wired-and: inactive level strong, active level weak
// - arrival source 00 target, 01 velocity, 11 compare flag
// - continuous compare; equality sets flag and pulses event
// - compare event is offered as an interrupt source output
// - compare select picks one of four operand pairs
// - clear-at-arrival zeroes position, restarts ramp if target nonzero
// - target may change anytime; clear whenever position equals target
// - circular mode confines position to minus range .. range-1
// - stepping past either end lands on the opposite end
// - circular positioning takes shortest direction, across wrap if shorter
// - range register written at 0x36, write only
// - fractional register at 0x7C added per completed revolution
// - accumulator overflow holds position at wrap one or two extra steps (integer part of the sum)
// - revolution counter counts up and down on wraps
// - reads at 0x36 give latch, or revolution count when selected
// - revolution counter forced to zero while circular is off
// - both virtual limits enabled bound a blocking zone in circular mode
// - positioning avoids the blocking zone even on a longer path
// - reaching a zone limit starts the virtual-stop deceleration
// - zone: at/below left or at/above right, or/and by limit order
// - virtual-stop ramp uses the stop deceleration factor to zero
`timescale 1ns/100ps
`default_nettype none
module pcm_position_supervisor #(
  parameter int unsigned POS_W = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic step_i,
  input wire logic step_up_i,
  input wire logic vel_reached_i,
  input wire logic [POS_W-1:0] home_position_i,
  input wire logic [POS_W-1:0] latched_position_i,
  output logic [POS_W-1:0] actual_position_o,
  output logic dir_up_o,
  output logic restart_o,
  output logic vstop_decel_o,
  output logic cmp_event_o,
  output logic arrival_o,
  output logic arrival_oe_o,
  output logic arrival_strong_o
);
  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic [31:0] gconf_reg;
  logic [31:0] rconf_reg;
  logic [POS_W-1:0] compare_reg;
  logic [POS_W-1:0] vleft_reg;
  logic [POS_W-1:0] vright_reg;
  logic [POS_W-1:0] range_reg;
  logic [POS_W-1:0] target_reg;
  logic [31:0] frac_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;
  logic req;
  logic wr;
  logic [7:0] idx;
  logic load_pos;
  logic [POS_W-1:0] actual;
  logic [POS_W-1:0] revs;

  function automatic logic [31:0] wmerge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  assign req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr = req && wb_we_i;
  assign idx = wb_adr_i[9:2];
  assign load_pos = wr && (idx == pcm_pkg::IDX_ACTUAL);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gconf_reg <= pcm_pkg::REG_RESET;
      rconf_reg <= pcm_pkg::REG_RESET;
      compare_reg <= '0;
      vleft_reg <= '0;
      vright_reg <= '0;
      range_reg <= '0;
      target_reg <= '0;
      frac_reg <= pcm_pkg::REG_RESET;
    end else if (wr) begin
      case (idx)
        pcm_pkg::IDX_GCONF: gconf_reg <= wmerge(gconf_reg, wb_dat_i, wb_sel_i);
        pcm_pkg::IDX_RCONF: rconf_reg <= wmerge(rconf_reg, wb_dat_i, wb_sel_i);
        pcm_pkg::IDX_COMPARE: compare_reg <= wmerge(compare_reg, wb_dat_i, wb_sel_i);
        pcm_pkg::IDX_VLEFT: vleft_reg <= wmerge(vleft_reg, wb_dat_i, wb_sel_i);
        pcm_pkg::IDX_VRIGHT: vright_reg <= wmerge(vright_reg, wb_dat_i, wb_sel_i);
        pcm_pkg::IDX_RANGE: range_reg <= wmerge(range_reg, wb_dat_i, wb_sel_i);
        pcm_pkg::IDX_TARGET: target_reg <= wmerge(target_reg, wb_dat_i, wb_sel_i);
        pcm_pkg::IDX_FRAC: frac_reg <= wmerge(frac_reg, wb_dat_i, wb_sel_i);
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // control decode
  // ---------------------------------------------------------------
  logic posmode;
  logic circ_on;
  logic at_target;
  logic cmp_hit;
  logic zone_on;
  logic in_zone;
  logic clr_req;
  logic fwd_up;
  logic short_up;
  logic crosses;
  logic dir_next;
  logic arr_active;
  logic arr_pull;
  logic arr_wand;
  logic [POS_W:0] diff;
  logic [POS_W:0] range_ext;
  logic [POS_W-1:0] lo_pos;
  logic [POS_W-1:0] hi_pos;
  logic [1:0] cmp_sel;
  logic [1:0] arr_src;
  logic cmp_flag_reg;

  assign posmode = gconf_reg[pcm_pkg::GC_POSMODE];
  assign arr_pull = gconf_reg[pcm_pkg::GC_PULL];
  assign arr_wand = gconf_reg[pcm_pkg::GC_WAND];
  assign cmp_sel = rconf_reg[pcm_pkg::RC_CMP_SEL +: 2];
  assign arr_src = rconf_reg[pcm_pkg::RC_ARR_SRC +: 2];
  assign circ_on = rconf_reg[pcm_pkg::RC_CIRC] && (range_reg != '0);
  assign at_target = (actual == target_reg);
  assign clr_req = posmode && rconf_reg[pcm_pkg::RC_CLR_AT] && at_target;
  assign zone_on = circ_on && rconf_reg[pcm_pkg::RC_VL_EN] && rconf_reg[pcm_pkg::RC_VR_EN];

  always_comb begin
    if ($signed(vleft_reg) < $signed(vright_reg)) begin
      in_zone = ($signed(actual) <= $signed(vleft_reg)) || ($signed(actual) >= $signed(vright_reg));
    end else begin
      in_zone = ($signed(actual) <= $signed(vleft_reg)) && ($signed(actual) >= $signed(vright_reg));
    end
  end

  always_comb begin
    case (cmp_sel)
      pcm_pkg::PCM_CMP_POS_VAL: cmp_hit = (actual == compare_reg);
      pcm_pkg::PCM_CMP_POS_HOME: cmp_hit = (actual == home_position_i);
      pcm_pkg::PCM_CMP_POS_LATCH: cmp_hit = (actual == latched_position_i);
      pcm_pkg::PCM_CMP_REV_VAL: cmp_hit = (revs == compare_reg);
      default: cmp_hit = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // direction choice
  // ---------------------------------------------------------------
  assign diff = {target_reg[POS_W-1], target_reg} - {actual[POS_W-1], actual};
  assign range_ext = {1'b0, range_reg};
  assign fwd_up = $signed(target_reg) > $signed(actual);
  assign lo_pos = fwd_up ? actual : target_reg;
  assign hi_pos = fwd_up ? target_reg : actual;
  assign crosses = ($signed(lo_pos) <= $signed(vleft_reg)) && ($signed(hi_pos) >= $signed(vright_reg));

  always_comb begin
    if ($signed(diff) > $signed(range_ext)) begin
      short_up = 1'b0;
    end else if ($signed(diff) < -$signed(range_ext)) begin
      short_up = 1'b1;
    end else begin
      short_up = fwd_up;
    end
  end

  // avoid the zone even if longer
  always_comb begin
    if (!circ_on) begin
      dir_next = fwd_up;
    end else if (zone_on) begin
      // a zone around the wrap point forbids wrapping; an inner zone forces it when crossed
      if ($signed(vleft_reg) < $signed(vright_reg)) begin
        dir_next = fwd_up;
      end else begin
        dir_next = crosses ? !fwd_up : fwd_up;
      end
    end else begin
      dir_next = short_up;
    end
  end

  // ---------------------------------------------------------------
  // position counter
  // ---------------------------------------------------------------
  pcm_circ_pos #(
    .POS_W(POS_W),
    .FRAC_W(32)
  ) u_pos (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .step_i(step_i),
    .step_up_i(step_up_i),
    .load_i(load_pos),
    .load_val_i(wb_dat_i[POS_W-1:0]),
    .clear_i(clr_req),
    .circ_on_i(circ_on),
    .range_i(range_reg),
    .frac_i(frac_reg),
    .actual_o(actual),
    .revs_o(revs)
  );
  assign actual_position_o = actual;

  // ---------------------------------------------------------------
  // motion outputs
  // ---------------------------------------------------------------
  logic restart_reg;
  logic vstop_reg;
  logic dir_reg;
  logic cmp_event_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_reg <= 1'b0;
      restart_reg <= 1'b0;
      vstop_reg <= 1'b0;
    end else begin
      dir_reg <= dir_next;
      restart_reg <= clr_req && (target_reg != '0);
      // start virtual-stop ramp; ramp unit uses stop factor
      vstop_reg <= zone_on && in_zone;
    end
  end

  // compare flag and event; event offered as interrupt source
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_flag_reg <= 1'b0;
      cmp_event_reg <= 1'b0;
    end else begin
      cmp_flag_reg <= cmp_hit;
      cmp_event_reg <= cmp_hit && !cmp_flag_reg;
    end
  end

  assign dir_up_o = dir_reg;
  assign restart_o = restart_reg;
  assign vstop_decel_o = vstop_reg;
  assign cmp_event_o = cmp_event_reg;

  // ---------------------------------------------------------------
  // arrival pin
  // ---------------------------------------------------------------
  logic arr_level_reg;
  logic arr_strong_reg;
  logic arr_oe_reg;

  // one flag forwarded; code 10 as target
  always_comb begin
    case (arr_src)
      pcm_pkg::PCM_ARR_TARGET: arr_active = at_target;
      pcm_pkg::PCM_ARR_VEL: arr_active = vel_reached_i;
      pcm_pkg::PCM_ARR_UNDEF: arr_active = at_target;
      pcm_pkg::PCM_ARR_CMP: arr_active = cmp_flag_reg;
      default: arr_active = at_target;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arr_level_reg <= 1'b0;
      arr_strong_reg <= 1'b0;
      arr_oe_reg <= 1'b0;
    end else begin
      arr_oe_reg <= 1'b1;
      arr_level_reg <= arr_active ^ gconf_reg[pcm_pkg::GC_INVPOL];
      // plain push-pull until the pull drive is enabled
      if (!arr_pull) begin
        arr_strong_reg <= 1'b1;
      end else if (arr_wand) begin
        arr_strong_reg <= !arr_active;
      end else begin
        arr_strong_reg <= arr_active;
      end
    end
  end

  assign arrival_o = arr_level_reg;
  assign arrival_strong_o = arr_strong_reg;
  assign arrival_oe_o = arr_oe_reg;

  // ---------------------------------------------------------------
  // bus read and acknowledge
  // ---------------------------------------------------------------
  always_comb begin
    dat_next = 32'h0000_0000;
    case (idx)
      pcm_pkg::IDX_GCONF: dat_next = gconf_reg;
      pcm_pkg::IDX_RCONF: dat_next = rconf_reg;
      pcm_pkg::IDX_STATUS: dat_next = {27'h000_0000, vstop_reg, in_zone, cmp_flag_reg,
                                       vel_reached_i, at_target};
      pcm_pkg::IDX_ACTUAL: dat_next = actual;
      pcm_pkg::IDX_COMPARE: dat_next = compare_reg;
      pcm_pkg::IDX_VLEFT: dat_next = vleft_reg;
      pcm_pkg::IDX_VRIGHT: dat_next = vright_reg;
      pcm_pkg::IDX_RANGE: dat_next = gconf_reg[pcm_pkg::GC_REVRD] ? revs : latched_position_i;
      pcm_pkg::IDX_TARGET: dat_next = target_reg;
      pcm_pkg::IDX_FRAC: dat_next = frac_reg;
      default: dat_next = 32'h0000_0000;
    endcase
  end

  // unmapped addresses still ack so a stray access cannot hang the bus
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req;
      if (req && !wb_we_i) begin
        dat_reg <= dat_next;
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_push_pull;
    !arr_pull ##1 !arr_pull |-> arrival_strong_o;
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("strong drive lost without pull");

  property p_wired_or;
    (arr_pull && !arr_wand && !arr_active) |=> !arrival_strong_o;
  endproperty
  a_wired_or: assert property (p_wired_or) else $error("wired-or inactive not weak");

  property p_wired_and;
    (arr_pull && arr_wand && arr_active) |=> !arrival_strong_o && arrival_oe_o;
  endproperty
  a_wired_and: assert property (p_wired_and) else $error("wired-and active not weak");

  property p_arr_src;
    (arr_src == pcm_pkg::PCM_ARR_CMP) |=>
      arrival_o == ($past(cmp_flag_reg) ^ $past(gconf_reg[pcm_pkg::GC_INVPOL]));
  endproperty
  a_arr_src: assert property (p_arr_src) else $error("arrival source wrong");

  property p_cmp_event;
    cmp_event_o |-> cmp_flag_reg && !$past(cmp_flag_reg);
  endproperty
  a_cmp_event: assert property (p_cmp_event) else $error("compare event without new hit");

  property p_cmp_sel;
    (cmp_sel == pcm_pkg::PCM_CMP_POS_VAL && actual == compare_reg) |=> cmp_flag_reg;
  endproperty
  a_cmp_sel: assert property (p_cmp_sel) else $error("compare flag missed");

  property p_clear;
    (clr_req && !load_pos) |=> (actual_position_o == '0) ##0 (restart_o == ($past(target_reg) != '0));
  endproperty
  a_clear: assert property (p_clear) else $error("clear at arrival failed");

  property p_rev_zero;
    !circ_on ##1 !circ_on |-> revs == '0;
  endproperty
  a_rev_zero: assert property (p_rev_zero) else $error("revolution count not zero");

  property p_rev_up;
    (circ_on && $past(circ_on) && revs == $past(revs) + POS_W'(1)) |->
      actual == POS_W'(~range_reg + POS_W'(1));
  endproperty
  a_rev_up: assert property (p_rev_up) else $error("revolution up without wrap");

  property p_vstop;
    (zone_on && in_zone) |=> vstop_decel_o;
  endproperty
  a_vstop: assert property (p_vstop) else $error("zone reached without stop");

  property p_rd_range;
    (req && !wb_we_i && idx == pcm_pkg::IDX_RANGE && gconf_reg[pcm_pkg::GC_REVRD]) |=>
      wb_ack_o && wb_dat_o == $past(revs);
  endproperty
  a_rd_range: assert property (p_rd_range) else $error("revolution readout wrong");

  c_cmp_event: cover property (cmp_event_o);
  c_restart: cover property (restart_o ##[1:50] restart_o);
  c_wrap: cover property (circ_on && revs != $past(revs));
  c_vstop: cover property (vstop_decel_o && dir_up_o);
endmodule // pcm_position_supervisor
`default_nettype wire

// ### bench/pcm_line_partner.sv
`timescale 1ns/100ps
`default_nettype none
// another controller on the shared arrival line
module pcm_line_partner (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic active_i,
  input wire logic wand_i,
  output logic line_o,
  output logic oe_o,
  output logic strong_o
);
  always_ff @(posedge clk_i) begin
    line_o <= active_i && !rst_i;
    oe_o <= !rst_i;
    strong_o <= wand_i ? !active_i : active_i;
  end
endmodule // pcm_line_partner
`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, step_i = 0, up = 0, vel = 0;
  logic [9:0] adr = 0;
  logic [31:0] dw = 0, home = 0, lat = 0, dr, act, q;
  logic ack, dir, rs, vs, ev, arr, aoe, ast, p_act = 0, p_wand = 0, p_l, p_oe, p_st, line;
  int miscompares = 0, check_count = 0, evn = 0, rsn = 0, cyc_n = 0, e0 = 0, r0 = 0;
  logic [31:0] arrx [4] = '{0, 1, 0, 1};
  logic [31:0] cmpx [4] = '{1, 1, 0, 0};
  pcm_position_supervisor dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dw), .wb_dat_o(dr),
    .wb_ack_o(ack), .step_i(step_i), .step_up_i(up), .vel_reached_i(vel),
    .home_position_i(home), .latched_position_i(lat), .actual_position_o(act),
    .dir_up_o(dir), .restart_o(rs), .vstop_decel_o(vs), .cmp_event_o(ev), .arrival_o(arr),
    .arrival_oe_o(aoe), .arrival_strong_o(ast));
  pcm_line_partner prt (.clk_i(clk_i), .rst_i(rst_i), .active_i(p_act), .wand_i(p_wand),
    .line_o(p_l), .oe_o(p_oe), .strong_o(p_st));
  // strong drive wins; two weak drivers that disagree leave the line unknown
  always_comb begin
    if (aoe && ast) line = arr;
    else if (p_oe && p_st) line = p_l;
    else if (aoe && p_oe && arr !== p_l) line = 1'bx;
    else line = aoe ? arr : p_l;
  end
  initial forever #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    evn <= evn + ev;
    rsn <= rsn + rs;
    cyc_n <= cyc_n + 1;
    if (cyc_n == 6000) begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= {idx, 2'b00};
    dw <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = dr;
    cyc <= 0;
    stb <= 0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    bus(0, idx, 0);
    check(q, exp);
  endtask
  task automatic step(input logic u, input int n);
    repeat (n) begin
      step_i <= 1;
      up <= u;
      @(posedge clk_i);
    end
    step_i <= 0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    rd(8'h00, 0);
    rd(8'h50, 0);
    tend("reset");
    bus(1, 8'h32, 3);
    bus(1, 8'h37, 7);
    bus(1, 8'h01, 3);
    // compare value 0 matches position 0 out of reset, so count from here
    e0 = evn;
    step(1, 3);
    rd(8'h0F, 32'h4);
    check(evn - e0, 1);
    vel <= 1;
    for (int i = 0; i < 4; i++) begin
      bus(1, 8'h01, i);
      check(arr, arrx[i]);
    end
    home <= 3;
    lat <= 9;
    for (int i = 0; i < 4; i++) begin
      bus(1, 8'h01, i << 3);
      bus(0, 8'h0F, 0);
      check(q[2], cmpx[i][0]);
    end
    tend("compare");
    check(ast, 1);
    bus(1, 8'h00, 32'h10);
    p_act <= 1;
    repeat (2) @(posedge clk_i);
    check({ast, line}, 2'b01);
    p_act <= 0;
    repeat (2) @(posedge clk_i);
    check(line, 0);
    bus(1, 8'h00, 32'h30);
    p_wand <= 1;
    p_act <= 1;
    check({ast, line}, 2'b10);
    bus(1, 8'h37, 3);
    check({ast, line}, 2'b01);
    tend("line");
    bus(1, 8'h01, 32'h20);
    bus(1, 8'h00, 32'h1);
    bus(1, 8'h37, 2);
    // position 3 already equalled target 3, so one clear has passed; count after it
    r0 = rsn;
    step(1, 1);
    bus(1, 8'h37, 1);
    rd(8'h21, 0);
    check(rsn > r0, 1);
    tend("repeat");
    bus(1, 8'h01, 32'h40);
    bus(1, 8'h00, 32'h40);
    bus(1, 8'h36, 2);
    bus(1, 8'h21, 1);
    step(1, 1);
    check(act, 32'hFFFF_FFFE);
    rd(8'h36, 1);
    step(0, 1);
    check(act, 1);
    rd(8'h36, 0);
    bus(1, 8'h7C, 32'h8000_0000);
    step(1, 1);
    check(act, 1);
    step(1, 1);
    check(act, 32'hFFFF_FFFE);
    rd(8'h36, 1);
    bus(1, 8'h01, 0);
    rd(8'h36, 0);
    tend("circular");
    bus(1, 8'h01, 32'h40);
    bus(1, 8'h36, 4);
    bus(1, 8'h21, 1);
    bus(1, 8'h37, 32'hFFFF_FFFC);
    check(dir, 1);
    bus(1, 8'h33, 32'hFFFF_FFFC);
    bus(1, 8'h34, 3);
    bus(1, 8'h01, 32'h1C0);
    check(dir, 0);
    bus(1, 8'h21, 3);
    check(vs, 1);
    tend("zone");
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
